// [logic/td_pkg.sv]
/*
  Constants, states and register map of the
  dual-channel torque disable monitor.
  Assumes a 125 MHz system clock.
*/
package td_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PULSE_MS  = 2;    // Test pulses ignored
  localparam int unsigned FILTER_MS = 6;    // Low must last this long
  localparam int unsigned TOL_MS    = 1600; // Skew never a fault
  localparam int unsigned FAULT_MS  = 2300; // Chosen threshold
  localparam int unsigned MAX_MS    = 3000; // Skew always a fault
  localparam int unsigned PULSE_CYC  = CYC_PER_MS * PULSE_MS;
  localparam int unsigned FILTER_CYC = CYC_PER_MS * FILTER_MS;
  localparam int unsigned FAULT_CYC  = CYC_PER_MS * FAULT_MS;
  // ----------------------------------------
  // Register indexes
  // ----------------------------------------
  localparam logic [3:0] A_CTRL    = 4'h0; // W: start, stop
  localparam logic [3:0] A_STATE   = 4'h1; // R: live state
  localparam logic [3:0] A_IRQ_ST  = 4'h2; // R: sticky events
  localparam logic [3:0] A_IRQ_CLR = 4'h3; // W: clear by one
  localparam logic [3:0] A_IRQ_EN  = 4'h4; // RW: enable
  localparam logic [3:0] A_H_CNT   = 4'h5; // R: history fill
  localparam logic [3:0] A_H_SEL   = 4'h6; // RW: history index
  localparam logic [3:0] A_H_DATA  = 4'h7; // R: selected entry
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;
  localparam int IRQ_FAULT  = 0;
  localparam int IRQ_TRIP   = 1;
  localparam int IRQ_HIST   = 2;
  localparam int IRQ_W      = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  // History entry codes
  localparam logic [1:0] CODE_START = 2'h1;
  localparam logic [1:0] CODE_RUN   = 2'h2;
  // Run state
  typedef enum logic [1:0] {
    RS_STOPPED = 2'b00,
    RS_RUNNING = 2'b01,
    RS_FAULT   = 2'b10
  } run_st_t;
endpackage

// [logic/td_link_if.sv]
/*
  Carrier between the monitor top, its input
  filter and its trip history store.
  Assumes all ends share one clock.
*/
`timescale 1ns/1ps
interface td_link_if #(
  parameter int HAW = 3
);
  logic [1:0]   raw;   // Pins, b then a
  logic [1:0]   filt;  // Filtered levels
  logic         push;  // Append one entry
  logic [1:0]   code;  // Entry to append
  logic [HAW-1:0] sel; // Entry to show
  logic [1:0]   entry; // Selected entry
  logic [HAW:0] count; // Entries held

  modport filt_mp (input raw, output filt);
  modport hist_mp (input push, code, sel, output entry, count);
  modport top_mp  (output raw, push, code, sel,
                   input filt, entry, count);
endinterface

// [logic/td_input_filter.sv]
/*
  Two-flop synchroniser and low-going filter
  for both safety inputs.
  Assumes raw pins are asynchronous to clk.
*/
`timescale 1ns/1ps
module td_input_filter
  import td_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = FILTER_CYC
)(
  input wire logic clk,    // System clock
  input wire logic resetn, // Async reset, low
  td_link_if.filt_mp lk    // Raw in, filtered out
);
  // Elaboration check, the low counter needs one cycle
  if (FILTER_CYCLES < 1)
  begin : g_bad_filter
    $error("FILTER_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic        s1;   // First sync flop
    logic        s2;   // Second sync flop
    logic        filt; // Filtered level
    logic [31:0] cnt;  // Cycles low so far
  } ch_st_t;

  // ----------------------------------------
  // One filter per channel
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      ch_st_t q;
      ch_st_t n;
      // Rising edge passes at once, low must persist
      always_comb
      begin
        n = q;
        n.s1 = lk.raw[g];
        n.s2 = q.s1;
        if (q.s2)
        begin
          n.cnt  = 32'h0000_0000;
          n.filt = 1'b1;
        end
        // short test pulses never reach here
        // react only after a full low spell
        else if (q.cnt >= 32'(FILTER_CYCLES - 1))
          n.filt = 1'b0;
        else
          n.cnt = q.cnt + 32'h0000_0001;
      end
      // State register, safe low at power-up
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          q <= '0;
        else
          q <= n;
      end
      assign lk.filt[g] = q.filt;
    end
  endgenerate
endmodule

// [logic/td_trip_history.sv]
/*
  Circular trip history store of small codes.
  Assumes one push per cycle at most.
*/
`timescale 1ns/1ps
module td_trip_history #(
  parameter int DEPTH = 8,
  parameter int HAW   = 3
)(
  input wire logic clk,    // System clock
  input wire logic resetn, // Async reset, low
  td_link_if.hist_mp lk    // Push and read side
);
  // Elaboration check, pointers wrap at a power of two
  if (DEPTH != (1 << HAW))
  begin : g_bad_depth
    $error("DEPTH must equal 2**HAW");
  end

  typedef struct packed {
    logic [HAW-1:0] wptr; // Next slot
    logic [HAW:0]   cnt;  // Fill, saturates
  } hist_st_t;

  hist_st_t   q;
  hist_st_t   n;
  logic [1:0] mem [DEPTH]; // Entry codes

  // Pointer and fill update
  always_comb
  begin
    n = q;
    if (lk.push)
    begin
      n.wptr = q.wptr + 1'b1;
      if (q.cnt != (HAW+1)'(DEPTH))
        n.cnt = q.cnt + 1'b1;
    end
  end

  // Oldest entry is overwritten when full
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= n;
  end

  always_ff @(posedge clk)
  begin
    if (lk.push)
      mem[q.wptr] <= lk.code;
  end

  assign lk.entry = mem[lk.sel];
  assign lk.count = q.cnt;
endmodule

// [logic/td_monitor.sv]
/*
  Dual-channel torque disable monitor: decodes
  the two safety inputs, times disagreement,
  latches a fault until power-up, keeps the run
  state, trip indication, history and irq.
  Assumes power-on reset only and a plain
  register port with read data one cycle later.
*/
// Local design decisions: the register offsets and strobed register access.
// How it works
// - Both low: trip, no power, status on
// - Both high: may run, status off
// - Inputs differ: tripped, status off
// - Skew up to 1.6 s no fault
// - Differ over 3.0 s always faults
// - Fault locks: tripped, status off
// - Only power cycle clears fault
// - Ignore low pulses under 2 ms
// - React after input low 6 ms
// - Trip when start with input low
// - Trip when input drops while running
// - Trip on circuit fault
// - History entry at refused start or running drop
// - No history entry for a drop when not running
`timescale 1ns/1ps
module td_monitor
  import td_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = FILTER_CYC,
  parameter int unsigned FAULT_CYCLES  = FAULT_CYC,
  parameter int          HIST_DEPTH    = 8
)(
  input  wire logic        clk,               // 125 MHz
  input  wire logic        resetn,            // Power-on reset
  input  wire logic        safety_input_a,    // Channel a pin
  input  wire logic        safety_input_b,    // Channel b pin
  input  wire logic [3:0]  addr,              // Register index
  input  wire logic [31:0] wr_data,           // Write data
  input  wire logic        wr_en,             // Write strobe
  input  wire logic        rd_en,             // Read strobe
  output logic      [31:0] rd_data,           // Read data
  output logic             motor_power_en,    // Power stage on
  output logic             run_active,        // Drive running
  output logic             trip_indication,   // Trip shown
  output logic             fault_latched,     // Locked fault
  output logic             status_output_pos, // Relay side a
  output logic             status_output_neg, // Relay side b
  output logic             irq                // Level interrupt
);
  localparam int HAW = $clog2(HIST_DEPTH);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Timer needs at least one cycle
  if (FAULT_CYCLES < 1)
  begin : g_bad_fault
    $error("FAULT_CYCLES must be at least 1");
  end
  // History needs an index bit
  if (HIST_DEPTH < 2)
  begin : g_bad_depth
    $error("HIST_DEPTH must be at least 2");
  end
  // Threshold must sit inside the skew window
  if (FAULT_MS <= TOL_MS || FAULT_MS >= MAX_MS)
  begin : g_bad_window
    $error("Fault threshold out of window");
  end
  // Filter must outlast a test pulse
  if (FILTER_MS <= PULSE_MS)
  begin : g_bad_pulse
    $error("Filter shorter than test pulse");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    run_st_t          st;      // Run state
    logic [31:0]      dis_cnt; // Disagree timer
    logic             pwr;     // Power stage on
    logic             run;     // Running flag
    logic             trip;    // Trip indication
    logic             flt;     // Fault copy
    logic             st_pos;  // Relay side a
    logic             st_neg;  // Relay side b
    logic [IRQ_W-1:0] irq_st;  // Sticky events
    logic [IRQ_W-1:0] irq_en;  // Event enables
    logic             irq;     // Interrupt line
    logic [HAW-1:0]   sel;     // History index
    logic [31:0]      rdata;   // Read data
    logic             push;    // History append
    logic [1:0]       code;    // Appended code
  } top_st_t;

  top_st_t q;      // Registered state
  top_st_t n;      // Next state
  logic    fa;     // Channel a filtered
  logic    fb;     // Channel b filtered
  logic    differ; // Channels disagree
  logic    td_on;  // Disable asked
  logic    start_p;// Start command
  logic    stop_p; // Stop command
  logic [IRQ_W-1:0] ev; // Events now

  td_link_if #(.HAW(HAW)) lk ();

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  assign lk.raw  = {safety_input_b, safety_input_a};
  assign lk.push = q.push;
  assign lk.code = q.code;
  assign lk.sel  = q.sel;

  td_input_filter #(
    .FILTER_CYCLES (FILTER_CYCLES)
  ) u_filter (
    .clk    (clk),
    .resetn (resetn),
    .lk     (lk.filt_mp)
  );

  td_trip_history #(
    .DEPTH (HIST_DEPTH),
    .HAW   (HAW)
  ) u_hist (
    .clk    (clk),
    .resetn (resetn),
    .lk     (lk.hist_mp)
  );

  // ----------------------------------------
  // Input decode and commands
  // ----------------------------------------
  assign fa      = lk.filt[0];
  assign fb      = lk.filt[1];
  assign differ  = fa ^ fb;
  assign td_on   = ~(fa & fb);
  assign start_p = wr_en && (addr == A_CTRL) && wr_data[CTRL_START];
  assign stop_p  = wr_en && (addr == A_CTRL) && wr_data[CTRL_STOP];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n      = q;
    n.push = 1'b0;
    ev     = '0;
    // Run state and history entries
    unique case (q.st)
      RS_STOPPED:
      begin
        if (start_p)
        begin
          if (td_on)
          begin
            n.push = 1'b1;
            n.code = CODE_START;
          end
          else
            n.st = RS_RUNNING;
        end
        // drop while stopped is not logged
      end
      RS_RUNNING:
      begin
        // input loss stops a running drive
        if (td_on)
        begin
          n.st   = RS_STOPPED;
          n.push = 1'b1;
          n.code = CODE_RUN;
        end
        else if (stop_p)
          n.st = RS_STOPPED;
      end
      RS_FAULT:
      begin
        if (start_p)
        begin
          n.push = 1'b1;
          n.code = CODE_START;
        end
      end
      default:
        n.st = RS_FAULT;
    endcase
    if (!differ)
      n.dis_cnt = 32'h0000_0000;
    else if (q.st != RS_FAULT)
    begin
      if (q.dis_cnt >= 32'(FAULT_CYCLES - 1))
      begin
        n.st  = RS_FAULT;
        ev[IRQ_FAULT] = 1'b1;
      end
      else
        n.dis_cnt = q.dis_cnt + 32'h0000_0001;
    end
    // nothing but reset leaves the fault
    if (q.st == RS_FAULT)
      n.st = RS_FAULT;
    n.flt = (n.st == RS_FAULT);
    n.run = (n.st == RS_RUNNING);
    // power only when both high and running
    n.pwr = fa && fb && n.run;
    n.trip = td_on || n.flt;
    // status on only in the safe state
    n.st_pos = !fa && !fb && !n.flt;
    n.st_neg = !n.st_pos;
    ev[IRQ_TRIP] = n.trip && !q.trip;
    ev[IRQ_HIST] = n.push;
    // Register writes, set beats clear
    if (wr_en && addr == A_IRQ_EN)
      n.irq_en = wr_data[IRQ_W-1:0];
    if (wr_en && addr == A_H_SEL)
      n.sel = wr_data[HAW-1:0];
    if (wr_en && addr == A_IRQ_CLR)
      n.irq_st = q.irq_st & ~wr_data[IRQ_W-1:0];
    n.irq_st = n.irq_st | ev;
    n.irq    = |(n.irq_st & n.irq_en);
    // Register reads, unmapped give zero
    n.rdata = 32'h0000_0000;
    if (rd_en)
    begin
      case (addr)
        A_STATE:
          n.rdata = 32'({q.st_pos, q.flt, q.trip, q.run, fb, fa});
        A_IRQ_ST:
          n.rdata = 32'(q.irq_st);
        A_IRQ_EN:
          n.rdata = 32'(q.irq_en);
        A_H_CNT:
          n.rdata = 32'(lk.count);
        A_H_SEL:
          n.rdata = 32'(q.sel);
        A_H_DATA:
          n.rdata = 32'(lk.entry);
        default:
          n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q        <= '0;
      q.st     <= RS_STOPPED;
      q.trip   <= 1'b1;
      q.st_neg <= 1'b1;
      q.irq_en <= IRQ_EN_RST;
    end
    else
      q <= n;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data           = q.rdata;
  assign motor_power_en    = q.pwr;
  assign run_active        = q.run;
  assign trip_indication   = q.trip;
  assign fault_latched     = q.flt;
  assign status_output_pos = q.st_pos;
  assign status_output_neg = q.st_neg;
  assign irq               = q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_start_refused;
    start_p && td_on && q.st == RS_STOPPED;
  endsequence

  sequence s_logged_once(logic [1:0] c);
    q.push && q.code == c ##1 !q.push;
  endsequence

  a_safe_state: assert property (
    (!fa && !fb && q.st != RS_FAULT) |=>
      status_output_pos && trip_indication && !motor_power_en)
    else $error("Safe state not shown");

  a_run_power: assert property (
    (fa && fb && q.st == RS_RUNNING && !stop_p) |=>
      motor_power_en && !status_output_pos)
    else $error("Power not given when enabled");

  a_one_chan: assert property (
    differ |=> trip_indication && !status_output_pos
      && !motor_power_en)
    else $error("Single channel not tripped");

  a_fault_time: assert property (
    (differ && q.st != RS_FAULT &&
     q.dis_cnt == 32'(FAULT_CYCLES - 1)) |=> fault_latched)
    else $error("Fault not declared at threshold");

  a_fault_cause: assert property (
    $rose(q.st == RS_FAULT) |->
      $past(q.dis_cnt) == 32'(FAULT_CYCLES - 1))
    else $error("Fault declared too early");

  a_fault_outputs: assert property (
    fault_latched |-> trip_indication && !status_output_pos
      && !motor_power_en && !run_active)
    else $error("Fault state outputs wrong");

  a_fault_lock: assert property (
    (q.st == RS_FAULT) |=> (q.st == RS_FAULT) [*2])
    else $error("Fault left without power cycle");

  a_timer_clear: assert property (
    !differ |=> q.dis_cnt == 32'h0000_0000)
    else $error("Timer not cleared on agreement");

  a_start_trip: assert property (
    s_start_refused |=> trip_indication && !run_active
      ##0 s_logged_once(CODE_START))
    else $error("Refused start not tripped");

  a_run_drop: assert property (
    (q.st == RS_RUNNING && td_on) |=> trip_indication
      && !motor_power_en ##0 s_logged_once(CODE_RUN))
    else $error("Running drop not tripped");

  a_no_history: assert property (
    (q.st != RS_RUNNING && !start_p) |=> !q.push)
    else $error("History written while stopped");
endmodule

// [bench/safety_relay_model.sv]
/*
  Model of the far-side safety relay that pulses both
  channels low in turn to find shorts between them.
  Assumes the monitor samples these pins on clk.
*/
`timescale 1ns/1ps
module safety_relay_model #(
  parameter int PULSE_LEN = 2
)(
  input  wire logic clk,     // System clock
  input  wire logic resetn,  // Async reset, low
  input  wire logic level_a, // Wanted level, channel a
  input  wire logic level_b, // Wanted level, channel b
  input  wire logic test_go, // Starts one pulse pair
  output logic      pin_a,   // Safety input a
  output logic      pin_b    // Safety input b
);
  int cnt_r; // Pulse phase, 0 when idle

  // Pulse sequencer, a first then b after a gap
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= 0;
    else if (cnt_r != 0)
      cnt_r <= (cnt_r >= 2 * PULSE_LEN + 4) ? 0 : cnt_r + 1;
    else if (test_go)
      cnt_r <= 1;
  end

  assign pin_a = level_a & !(cnt_r >= 1 && cnt_r <= PULSE_LEN);
  assign pin_b = level_b & !(cnt_r >= PULSE_LEN + 3 && cnt_r <= 2 * PULSE_LEN + 2);
endmodule

// [bench/td_monitor_tb_top.sv]
/*
  Self-checking bench for the torque disable monitor.
  Assumes short filter and fault counts set below.
*/
`timescale 1ns/1ps
module td_monitor_tb_top;
  import td_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk;        // System clock
  logic        resetn;     // Reset, low
  logic [3:0]  addr;       // Register index
  logic [31:0] wr_data;    // Write data
  logic        wr_en;      // Write strobe
  logic        rd_en;      // Read strobe
  logic [31:0] rd_data;    // Read data
  logic        level_a;    // Relay level a
  logic        level_b;    // Relay level b
  logic        test_go;    // Pulse request
  logic        pin_a;      // Pin a
  logic        pin_b;      // Pin b
  logic        power;      // Power stage on
  logic        run;        // Running
  logic        trip;       // Trip shown
  logic        fault;      // Locked fault
  logic        st_pos;     // Status side a
  logic        st_neg;     // Status side b
  logic        irq;        // Interrupt
  wire  [5:0]  outs = {power, run, trip, fault, st_pos, st_neg}; // Output set
  int          mismatches; // Failed compares
  int          tests_run;  // All compares

  safety_relay_model #(.PULSE_LEN(2)) relay (.clk(clk), .resetn(resetn), .level_a(level_a),
    .level_b(level_b), .test_go(test_go), .pin_a(pin_a), .pin_b(pin_b));

  td_monitor #(.FILTER_CYCLES(4), .FAULT_CYCLES(20), .HIST_DEPTH(8)) dut (.clk(clk),
    .resetn(resetn), .safety_input_a(pin_a), .safety_input_b(pin_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .motor_power_en(power), .run_active(run), .trip_indication(trip),
    .fault_latched(fault), .status_output_pos(st_pos), .status_output_neg(st_neg),
    .irq(irq));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let n edges pass, then settle
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // Read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // Relay levels change right after a clock edge
  task automatic drive_lv(input logic a, input logic b);
    @(posedge clk);
    level_a <= a;
    level_b <= b;
  endtask

  // ----------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short
  initial
  begin
    #(8 * 4000);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    {addr, wr_data, wr_en, rd_en, test_go} = '0;
    level_a = 1'b1;
    level_b = 1'b1;
    resetn  = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wait_cyc(10);
    chk({26'h0, outs}, 32'h0000_0001);
    rd(A_STATE, 32'h0000_0003);
    // Read data stand for one cycle only
    wait_cyc(1);
    chk(rd_data, 32'h0000_0000);
    rd(A_IRQ_EN, 32'h0000_0000);
    rd(4'h9, 32'h0000_0000);
    wr(A_IRQ_EN, 32'h0000_0007);
    rd(A_IRQ_EN, 32'h0000_0007);
    wr(A_CTRL, 32'h0000_0001);
    wait_cyc(1);
    chk({26'h0, outs}, 32'h0000_0031);
    // Stop is a plain halt, no history entry
    wr(A_CTRL, 32'h0000_0002);
    wait_cyc(1);
    chk({26'h0, outs}, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_0001);
    wait_cyc(1);
    chk({26'h0, outs}, 32'h0000_0031);
    @(posedge clk);
    test_go <= 1'b1;
    @(posedge clk);
    test_go <= 1'b0;
    wait_cyc(20);
    chk({26'h0, outs}, 32'h0000_0031);
    rd(A_H_CNT, 32'h0000_0000);
    drive_lv(1'b0, 1'b1);
    wait_cyc(4);
    chk({26'h0, outs}, 32'h0000_0031);
    drive_lv(1'b0, 1'b0);
    wait_cyc(8);
    chk({26'h0, outs}, 32'h0000_000A);
    rd(A_STATE, 32'h0000_0028);
    rd(A_IRQ_ST, 32'h0000_0006);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(A_H_CNT, 32'h0000_0001);
    wr(A_H_SEL, 32'h0000_0000);
    rd(A_H_DATA, {30'h0, CODE_RUN});
    wr(A_IRQ_CLR, 32'h0000_0007);
    rd(A_IRQ_ST, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0001);
    wait_cyc(1);
    chk({26'h0, outs}, 32'h0000_000A);
    rd(A_H_CNT, 32'h0000_0002);
    wr(A_H_SEL, 32'h0000_0001);
    rd(A_H_DATA, {30'h0, CODE_START});
    drive_lv(1'b1, 1'b1);
    wait_cyc(6);
    drive_lv(1'b0, 1'b0);
    wait_cyc(10);
    rd(A_H_CNT, 32'h0000_0002);
    drive_lv(1'b1, 1'b0);
    wait_cyc(5);
    chk({26'h0, outs}, 32'h0000_0009);
    wait_cyc(10);
    drive_lv(1'b1, 1'b1);
    wait_cyc(5);
    chk({26'h0, outs}, 32'h0000_0001);
    drive_lv(1'b1, 1'b0);
    wait_cyc(18);
    drive_lv(1'b1, 1'b1);
    wait_cyc(6);
    chk({26'h0, outs}, 32'h0000_0001);
    drive_lv(1'b0, 1'b1);
    wait_cyc(40);
    chk({26'h0, outs}, 32'h0000_000D);
    rd(A_IRQ_ST, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(A_IRQ_EN, 32'h0000_0000);
    wait_cyc(2);
    chk({31'h0, irq}, 32'h0000_0000);
    drive_lv(1'b0, 1'b0);
    wait_cyc(10);
    chk({26'h0, outs}, 32'h0000_000D);
    drive_lv(1'b1, 1'b1);
    wait_cyc(6);
    wr(A_CTRL, 32'h0000_0001);
    wait_cyc(1);
    chk({26'h0, outs}, 32'h0000_000D);
    // Power cycle: reset levels shown, then the fault is gone
    @(posedge clk);
    resetn <= 1'b0;
    wait_cyc(7);
    chk({26'h0, outs}, 32'h0000_0009);
    @(posedge clk);
    resetn <= 1'b1;
    wait_cyc(10);
    chk({26'h0, outs}, 32'h0000_0001);
    give_verdict();
  end
endmodule
